// ### logic/lsqr_pkg.sv
// Package for the link status query responder: packet layout, codes and states.
// Assumes a byte-wide command and response stream, most significant byte of each word first.
package lsqr_pkg;

  // ----------------------------------------------------------------
  // Packet codes and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] LSQR_CMD_TYPE = 8'h0A;
  localparam logic [7:0] LSQR_RSP_TYPE = 8'h8A;
  // Position of the packet type byte inside the 16-byte control header.
  localparam int LSQR_TYPE_POS = 4;
  localparam int LSQR_HDR_LEN = 16;
  localparam int LSQR_CMD_LEN = 46;
  localparam int LSQR_RSP_LEN = 46;
  localparam logic [5:0] LSQR_RCODE_POS = 6'h10;
  localparam logic [5:0] LSQR_LINK_POS = 6'h14;
  localparam logic [5:0] LSQR_OTHER_POS = 6'h18;
  localparam logic [5:0] LSQR_OEM_POS = 6'h1C;
  localparam logic [5:0] LSQR_CSUM_POS = 6'h20;
  localparam logic [5:0] LSQR_PAD_POS = 6'h24;
  localparam logic [5:0] LSQR_RSP_LAST = 6'h2D;
  localparam logic [15:0] LSQR_RSP_CODE_OK = 16'h0000;
  localparam logic [15:0] LSQR_REASON_NONE = 16'h0000;
  // A zero checksum tells the receiver that no checksum was computed.
  localparam logic [31:0] LSQR_CSUM_NONE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Link status word fields
  // ----------------------------------------------------------------
  localparam int LSQR_LS_UP = 0;
  localparam int LSQR_LS_SPD_LO = 1;
  localparam int LSQR_LS_AN_EN = 5;
  localparam int LSQR_LS_AN_DONE = 6;
  localparam int LSQR_LS_PAR_DET = 7;
  localparam int LSQR_LS_ENH_LO = 24;

  // ----------------------------------------------------------------
  // Speed and duplex codes
  // ----------------------------------------------------------------
  localparam logic [3:0] LSQR_SPD_NONE = 4'h0;
  localparam logic [3:0] LSQR_SPD_UNLISTED = 4'h5;
  localparam logic [3:0] LSQR_SPD_10G = 4'h8;
  localparam logic [3:0] LSQR_SPD_100G = 4'hD;
  localparam logic [3:0] LSQR_SPD_UNDEF = 4'hE;
  localparam logic [3:0] LSQR_SPD_ENH = 4'hF;

  typedef enum logic [0:0] {
    LSQR_RECV,
    LSQR_SEND
  } lsqr_state_t;

endpackage

// ### logic/lsqr_responder.sv
// Top of the link status query responder: parses the query and streams the response.
// Assumes checksum and identifier checks are done upstream and flagged with the last byte,
// and that all status inputs come from logic on the same clock.
`timescale 1ns/100ps

// Overview of operation
// R1: Query type 0x0A answered with type 0x8A.
// R2: Query: header, checksum, then padding bytes.
// R3: Valid, matching query always gets a response.
// R4: Response words placed at documented byte offsets.
// R5: Bit 0 shows link up or down.
// R6: Low power idle still reports link up.
// R7: Bits 4..1 hold speed and duplex code.
// R8: Codes 0x8..0xD give 10 to 100 Gbps.
// R9: Code zero when unresolved, serial lane, none.
// R10: Code 0xF points to enhanced field, bit 24.
// R11: Forced link code allowed without serial lane.
// R12: Unlisted modes report nearest listed code.
// R13: Controller should not infer media from code.
// R14: Bit 5 set only when negotiation enabled.
// R15: Bit 6 set only when negotiation completed.
// R16: Bit 7 marks link via parallel detection.
// R17: Bad checksum or identifiers gets no response.
module lsqr_responder
  import lsqr_pkg::*;
#(
  parameter bit ENH_SPEED_EN = 1'b1,
  parameter bit AN_SUPPORTED = 1'b1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command byte stream
  input wire logic cmdValid,
  input wire logic [7:0] cmdData,
  input wire logic cmdLast,
  input wire logic cmdCheckOk,
  input wire logic cmdIdMatch,
  output logic cmdReady,
  // Response byte stream
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspLast,
  input wire logic rspReady,
  // Events
  output logic queryDropped,
  // Link state
  input wire logic linkUp,
  input wire logic energyEfficientEthernet,
  input wire logic lowPowerIdleState,
  input wire logic anEnabled,
  input wire logic anComplete,
  input wire logic parallelDetect,
  input wire logic serdesLink,
  input wire logic modeValid,
  input wire logic [3:0] highestCommonMode,
  input wire logic [7:0] enhancedSpeed,
  input wire logic [31:0] otherIndications,
  input wire logic [31:0] oemLinkStatus
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (LSQR_TYPE_POS >= LSQR_HDR_LEN)
  begin : gTypePosCheck
    $error("Type byte position must lie inside the header");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lsqr_state_t state_q;
  lsqr_state_t state_d;
  logic [5:0] rxCnt_q;
  logic [5:0] rxCnt_d;
  logic [7:0] hdr_q [LSQR_HDR_LEN];
  logic [7:0] hdr_d [LSQR_HDR_LEN];
  logic [31:0] linkWord_q;
  logic [31:0] linkWord_d;
  logic [31:0] other_q;
  logic [31:0] other_d;
  logic [31:0] oem_q;
  logic [31:0] oem_d;
  logic [5:0] txIdx_q;
  logic [5:0] txIdx_d;
  logic cmdReady_q;
  logic cmdReady_d;
  logic rspValid_q;
  logic rspValid_d;
  logic [7:0] rspData_q;
  logic [7:0] rspData_d;
  logic rspLast_q;
  logic rspLast_d;
  logic drop_q;
  logic drop_d;
  logic [8*LSQR_HDR_LEN-1:0] hdrFlat;
  logic [5:0] muxIdx;
  logic [7:0] muxByte;
  logic [3:0] speedCode;
  logic useEnhanced;
  logic [31:0] linkWordNow;
  logic anFlag;
  logic anDone;
  logic typeByteOk;
  logic cmdTake;

  // ----------------------------------------------------------------
  // Header flattening, type byte replaced for the response
  // ----------------------------------------------------------------
  for (genvar g = 0; g < LSQR_HDR_LEN; g++)
  begin : gHdr
    if (g == LSQR_TYPE_POS)
    begin : gType
      assign hdrFlat[8*g +: 8] = LSQR_RSP_TYPE; // [R1]
    end
    else
    begin : gCopy
      assign hdrFlat[8*g +: 8] = hdr_q[g];
    end
  end

  // ----------------------------------------------------------------
  // Link status word
  // ----------------------------------------------------------------
  lsqr_speed_enc #(
    .ENH_SPEED_EN(ENH_SPEED_EN)
  ) uSpeed (
    .anEnabled(anFlag),
    .anComplete(anComplete),
    .serdesLink(serdesLink),
    .modeValid(modeValid),
    .highestCommonMode(highestCommonMode),
    .speedCode(speedCode),
    .useEnhanced(useEnhanced)
  );

  always_comb
  begin
    anFlag = AN_SUPPORTED && anEnabled; // [R14]
    anDone = anFlag && anComplete; // [R15]
    linkWordNow = 32'h0000_0000;
    // Low power idle keeps the link reported as up while the feature is on.
    linkWordNow[LSQR_LS_UP] = linkUp || (energyEfficientEthernet && lowPowerIdleState); // [R5] [R6]
    linkWordNow[LSQR_LS_SPD_LO +: 4] = speedCode; // [R7] [R8] [R9]
    linkWordNow[LSQR_LS_AN_EN] = anFlag; // [R14]
    linkWordNow[LSQR_LS_AN_DONE] = anDone; // [R15]
    linkWordNow[LSQR_LS_PAR_DET] = anDone && parallelDetect && linkUp; // [R16]
    if (useEnhanced)
    begin
      linkWordNow[LSQR_LS_ENH_LO +: 8] = enhancedSpeed; // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Response byte selection
  // ----------------------------------------------------------------
  lsqr_rsp_mux uMux (
    .byteIdx(muxIdx),
    .header(hdrFlat),
    .linkWord(linkWord_q),
    .otherWord(other_q),
    .oemWord(oem_q),
    .byteOut(muxByte)
  );

  // The next byte is looked up one index ahead so that it is loaded with the take,
  // and the lookup stays outside the control process that reads its result.
  assign muxIdx = (state_q == LSQR_SEND && rspValid_q && rspReady && txIdx_q != LSQR_RSP_LAST)
    ? txIdx_q + 6'h01 : txIdx_q;

  // ----------------------------------------------------------------
  // Receive and send control
  // ----------------------------------------------------------------
  // The status words are sampled when the query is accepted, so one response
  // is self-consistent even if the link changes while it is being sent.
  always_comb
  begin
    state_d = state_q;
    rxCnt_d = rxCnt_q;
    hdr_d = hdr_q;
    linkWord_d = linkWord_q;
    other_d = other_q;
    oem_d = oem_q;
    txIdx_d = txIdx_q;
    cmdReady_d = cmdReady_q;
    rspValid_d = rspValid_q;
    rspData_d = rspData_q;
    rspLast_d = rspLast_q;
    drop_d = 1'b0;
    cmdTake = cmdValid && cmdReady_q;
    typeByteOk = (hdr_q[LSQR_TYPE_POS] == LSQR_CMD_TYPE);
    unique case (state_q)
      LSQR_RECV:
      begin
        if (cmdTake)
        begin
          if (rxCnt_q < 6'(LSQR_HDR_LEN))
          begin
            hdr_d[rxCnt_q[3:0]] = cmdData; // [R2]
          end
          if (rxCnt_q != 6'h3F)
          begin
            rxCnt_d = rxCnt_q + 6'h01;
          end
          if (cmdLast)
          begin
            rxCnt_d = 6'h00;
            // The type byte is never the last byte of a frame that reaches here
            // complete, so the stored copy is already current.
            if (typeByteOk && rxCnt_q >= 6'(LSQR_HDR_LEN) && cmdCheckOk && cmdIdMatch) // [R1] [R3]
            begin
              state_d = LSQR_SEND;
              linkWord_d = linkWordNow;
              other_d = otherIndications;
              oem_d = oemLinkStatus;
              txIdx_d = 6'h00;
              cmdReady_d = 1'b0;
            end
            else
            begin
              drop_d = !(typeByteOk && rxCnt_q >= 6'(LSQR_HDR_LEN)) ? 1'b0 : 1'b1; // [R17]
            end
          end
        end
        if (state_q == LSQR_RECV && state_d == LSQR_SEND)
        begin
          rspValid_d = 1'b1;
          rspLast_d = 1'b0;
        end
      end
      LSQR_SEND:
      begin
        // First byte is loaded one cycle after acceptance, once status is held.
        if (!rspValid_q)
        begin
          rspValid_d = 1'b1;
        end
        if (rspValid_q && rspReady)
        begin
          if (txIdx_q == LSQR_RSP_LAST)
          begin
            state_d = LSQR_RECV;
            rspValid_d = 1'b0;
            rspLast_d = 1'b0;
            cmdReady_d = 1'b1;
          end
          else
          begin
            txIdx_d = txIdx_q + 6'h01;
            rspData_d = muxByte; // [R4]
            rspLast_d = (txIdx_d == LSQR_RSP_LAST);
          end
        end
        else if (txIdx_q == 6'h00 && !rspLast_q)
        begin
          rspData_d = muxByte; // [R4]
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= LSQR_RECV;
      rxCnt_q <= 6'h00;
      for (int i = 0; i < LSQR_HDR_LEN; i++)
      begin
        hdr_q[i] <= 8'h00;
      end
      linkWord_q <= 32'h0000_0000;
      other_q <= 32'h0000_0000;
      oem_q <= 32'h0000_0000;
      txIdx_q <= 6'h00;
      cmdReady_q <= 1'b1;
      rspValid_q <= 1'b0;
      rspData_q <= 8'h00;
      rspLast_q <= 1'b0;
      drop_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rxCnt_q <= rxCnt_d;
      hdr_q <= hdr_d;
      linkWord_q <= linkWord_d;
      other_q <= other_d;
      oem_q <= oem_d;
      txIdx_q <= txIdx_d;
      cmdReady_q <= cmdReady_d;
      rspValid_q <= rspValid_d;
      rspData_q <= rspData_d;
      rspLast_q <= rspLast_d;
      drop_q <= drop_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmdReady = cmdReady_q;
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign rspLast = rspLast_q;
  assign queryDropped = drop_q;

endmodule

// ### logic/lsqr_rsp_mux.sv
// Byte selector for the link status response packet.
// Assumes header and status words are held stable by the caller while a packet is sent.
`timescale 1ns/100ps
module lsqr_rsp_mux
  import lsqr_pkg::*;
(
  // Selection
  input wire logic [5:0] byteIdx,
  // Packet content
  input wire logic [8*LSQR_HDR_LEN-1:0] header,
  input wire logic [31:0] linkWord,
  input wire logic [31:0] otherWord,
  input wire logic [31:0] oemWord,
  // Result
  output logic [7:0] byteOut
);

  logic [31:0] word;
  logic [1:0] lane;

  always_comb
  begin
    word = 32'h0000_0000;
    lane = byteIdx[1:0];
    if (byteIdx < LSQR_LINK_POS)
    begin
      word = {LSQR_RSP_CODE_OK, LSQR_REASON_NONE};
    end
    else if (byteIdx < LSQR_OTHER_POS)
    begin
      word = linkWord;
    end
    else if (byteIdx < LSQR_OEM_POS)
    begin
      word = otherWord;
    end
    else if (byteIdx < LSQR_CSUM_POS)
    begin
      word = oemWord;
    end
    else if (byteIdx < LSQR_PAD_POS)
    begin
      word = LSQR_CSUM_NONE;
    end
    // Each word goes out most significant byte first. [R4]
    byteOut = word[8*(3-lane) +: 8];
    if (byteIdx < LSQR_RCODE_POS)
    begin
      byteOut = header[8*byteIdx[3:0] +: 8]; // [R4]
    end
  end

endmodule

// ### logic/lsqr_speed_enc.sv
// Speed and duplex code filter for the link status word.
// Assumes the resolved mode code and its valid flag come from the PHY logic on the same clock.
`timescale 1ns/100ps
module lsqr_speed_enc
  import lsqr_pkg::*;
#(
  parameter bit ENH_SPEED_EN = 1'b1
)
(
  // Link state
  input wire logic anEnabled,
  input wire logic anComplete,
  input wire logic serdesLink,
  input wire logic modeValid,
  input wire logic [3:0] highestCommonMode,
  // Result
  output logic [3:0] speedCode,
  output logic useEnhanced
);

  always_comb
  begin
    speedCode = highestCommonMode;
    if (serdesLink || !modeValid || (anEnabled && !anComplete))
    begin
      speedCode = LSQR_SPD_NONE; // [R9]
    end
    else if (highestCommonMode == LSQR_SPD_UNLISTED)
    begin
      // An unlisted gigabit-class mode is reported as the closest listed one.
      speedCode = LSQR_SPD_UNLISTED + 4'h1; // [R12]
    end
    else if (highestCommonMode == LSQR_SPD_UNDEF)
    begin
      speedCode = LSQR_SPD_100G; // [R8] [R12]
    end
    else if (highestCommonMode == LSQR_SPD_ENH && !ENH_SPEED_EN)
    begin
      speedCode = LSQR_SPD_100G; // [R10] [R12]
    end
    // With auto-negotiation off a valid forced mode is still reported unless serdesLink is set. [R11]
    useEnhanced = (speedCode == LSQR_SPD_ENH); // [R10]
  end

endmodule

// ### test/lsqr_chk.sv
// Port checker for the link status query responder.
// Assumes whole 46-byte queries and a single clock domain.
`timescale 1ns/100ps
module lsqr_chk
  import lsqr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command stream
  input wire logic cmdValid,
  input wire logic [7:0] cmdData,
  input wire logic cmdLast,
  input wire logic cmdCheckOk,
  input wire logic cmdIdMatch,
  input wire logic cmdReady,
  // Response stream
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic rspLast,
  input wire logic rspReady,
  input wire logic queryDropped,
  // Link state
  input wire logic linkUp,
  input wire logic energyEfficientEthernet,
  input wire logic lowPowerIdleState,
  input wire logic anEnabled,
  input wire logic anComplete,
  input wire logic serdesLink
);
  logic [5:0] cmdCnt_q, cmdCnt_d, rspCnt_q, rspCnt_d;
  logic typeOk_q, typeOk_d, take, full, good, bad, lw;

  assign take = cmdValid && cmdReady;
  assign full = take && cmdLast && cmdCnt_q == 6'h2D && typeOk_q;
  assign good = full && cmdCheckOk && cmdIdMatch;
  assign bad = full && !(cmdCheckOk && cmdIdMatch);
  // Low byte of the link word, as it is taken.
  assign lw = rspValid && rspReady && rspCnt_q == 6'h17;

  always_comb
  begin
    cmdCnt_d = cmdCnt_q;
    typeOk_d = typeOk_q;
    rspCnt_d = rspCnt_q;
    if (take)
      cmdCnt_d = cmdLast ? 6'h00 : cmdCnt_q + 6'h01;
    if (take && cmdCnt_q == 6'h04)
      typeOk_d = cmdData == LSQR_CMD_TYPE;
    if (rspValid && rspReady)
      rspCnt_d = rspCnt_q + 6'h01;
    if (good)
      rspCnt_d = 6'h00;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmdCnt_q <= 6'h00;
      typeOk_q <= 1'b0;
      rspCnt_q <= 6'h00;
    end
    else
    begin
      cmdCnt_q <= cmdCnt_d;
      typeOk_q <= typeOk_d;
      rspCnt_q <= rspCnt_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence rspOpens; rspValid && !cmdReady; endsequence
  sequence dropPulse; queryDropped ##1 !queryDropped; endsequence

  a_query_answered: assert property (good |=> rspOpens)
    else $error("good query not answered");
  a_drop_pulse: assert property (bad |=> dropPulse)
    else $error("rejected query gave no single drop pulse");
  a_no_rsp_bad: assert property (bad |=> !rspValid [*2])
    else $error("rejected query was answered");
  a_busy_refuse: assert property (rspValid |-> !cmdReady)
    else $error("command bytes accepted while responding");
  a_rsp_type: assert property (rspValid && rspReady && rspCnt_q == 6'h04 |-> rspData == LSQR_RSP_TYPE)
    else $error("response type byte wrong");
  a_last_byte: assert property (rspValid && rspReady |-> rspLast == (rspCnt_q == LSQR_RSP_LAST))
    else $error("last flag not on byte 45");
  a_ready_back: assert property (rspValid && rspReady && rspLast |=> !rspValid && cmdReady)
    else $error("stream not closed after byte 45");
  a_link_flag: assert property (lw |-> rspData[0] == (linkUp || energyEfficientEthernet && lowPowerIdleState))
    else $error("link flag wrong");
  a_an_bits: assert property (lw |-> rspData[6:5] == {anEnabled && anComplete, anEnabled})
    else $error("negotiation bits wrong");
  a_code_zero: assert property (lw && (serdesLink || anEnabled && !anComplete) |-> rspData[4:1] == 4'h0)
    else $error("speed code not zero");
endmodule

bind lsqr_responder lsqr_chk i_chk (.clk(clk), .rstn(rstn), .cmdValid(cmdValid),
  .cmdData(cmdData), .cmdLast(cmdLast), .cmdCheckOk(cmdCheckOk), .cmdIdMatch(cmdIdMatch),
  .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast),
  .rspReady(rspReady), .queryDropped(queryDropped), .linkUp(linkUp),
  .energyEfficientEthernet(energyEfficientEthernet), .lowPowerIdleState(lowPowerIdleState),
  .anEnabled(anEnabled), .anComplete(anComplete), .serdesLink(serdesLink));

// ### test/lsqr_mc_model.sv
// Management controller model: sends query frames and collects responses.
// Assumes its tasks are called at a falling clock edge.
`timescale 1ns/100ps
module lsqr_mc_model
(
  // Clock
  input wire logic clk,
  // Command side
  output logic cmdValid,
  output logic [7:0] cmdData,
  output logic cmdLast,
  output logic cmdCheckOk,
  output logic cmdIdMatch,
  input wire logic cmdReady,
  // Response side
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic rspLast,
  output logic rspReady
);
  logic [7:0] rsp [0:45];
  logic [45:0] lastSeen;

  initial
  begin
    cmdValid = 1'b0;
    cmdData = 8'h00;
    cmdLast = 1'b0;
    cmdCheckOk = 1'b0;
    cmdIdMatch = 1'b0;
    rspReady = 1'b0;
  end

  // Header, checksum and padding bytes, type code in header byte 4.
  task automatic send(input logic [7:0] typeCode, input logic chk, input logic id);
    int i;
    for (i = 0; i < 46; i++)
    begin
      cmdValid = 1'b1;
      cmdData = (i == 4) ? typeCode : 8'(i) ^ 8'h5A;
      cmdLast = i == 45;
      cmdCheckOk = chk;
      cmdIdMatch = id;
      while (!cmdReady)
        @(negedge clk);
      @(negedge clk);
    end
    cmdValid = 1'b0;
    cmdLast = 1'b0;
    // Released data lines change so a stale byte is never mistaken for a held one.
    cmdData = ~cmdData;
  endtask

  // Byte 0 loads one cycle after the stream opens, so ready stays low for that cycle.
  task automatic recv(input bit stall);
    int i;
    while (!rspValid)
      @(negedge clk);
    @(negedge clk);
    for (i = 0; i < 46; i++)
    begin
      if (stall && i % 5 == 2)
      begin
        rspReady = 1'b0;
        @(negedge clk);
      end
      rspReady = 1'b1;
      // Bytes are kept as plain numbers; no media type is drawn from the speed code.
      rsp[i] = rspData;
      lastSeen[i] = rspLast;
      @(negedge clk);
    end
    rspReady = 1'b0;
  endtask
endmodule

// ### test/test_link_status_query_responder.sv
// Bench for the link status query responder.
// Assumes the controller model and the bound port checker.
`timescale 1ns/100ps
module test_link_status_query_responder
  import lsqr_pkg::*;
;
  logic clk, rstn, cmdValid, cmdLast, cmdCheckOk, cmdIdMatch, cmdReady;
  logic rspValid, rspLast, rspReady, queryDropped, linkUp, energyEfficientEthernet;
  logic lowPowerIdleState, anEnabled, anComplete, parallelDetect, serdesLink, modeValid;
  logic [7:0] cmdData, rspData, enhancedSpeed;
  logic [3:0] highestCommonMode;
  logic [31:0] otherIndications, oemLinkStatus;
  int failures, check_count, cycles, m;

  lsqr_responder i_dut (.clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdData(cmdData),
    .cmdLast(cmdLast), .cmdCheckOk(cmdCheckOk), .cmdIdMatch(cmdIdMatch), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast), .rspReady(rspReady),
    .queryDropped(queryDropped), .linkUp(linkUp),
    .energyEfficientEthernet(energyEfficientEthernet), .lowPowerIdleState(lowPowerIdleState),
    .anEnabled(anEnabled), .anComplete(anComplete), .parallelDetect(parallelDetect),
    .serdesLink(serdesLink), .modeValid(modeValid), .highestCommonMode(highestCommonMode),
    .enhancedSpeed(enhancedSpeed), .otherIndications(otherIndications),
    .oemLinkStatus(oemLinkStatus));

  lsqr_mc_model i_mc (.clk(clk), .cmdValid(cmdValid), .cmdData(cmdData), .cmdLast(cmdLast),
    .cmdCheckOk(cmdCheckOk), .cmdIdMatch(cmdIdMatch), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast), .rspReady(rspReady));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // About 25 queries of some 95 cycles each; the ceiling leaves ample margin.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      failures++;
      end_sim;
    end
  end

  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    chkByte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic end_sim;
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Sets the link state, runs one good query and checks every response byte.
  task automatic run(input logic up, ane, anc, pd, sd, input logic [3:0] mode, code,
    input bit stall);
    logic [95:0] v;
    logic [7:0] e;
    int i;
    linkUp = up;
    anEnabled = ane;
    anComplete = anc;
    parallelDetect = pd;
    serdesLink = sd;
    highestCommonMode = mode;
    v = {code == 4'hF ? enhancedSpeed : 8'h00, 16'h0000, ane & anc & pd & up, ane & anc, ane,
      code, up | (energyEfficientEthernet & lowPowerIdleState), otherIndications, oemLinkStatus};
    i_mc.send(LSQR_CMD_TYPE, 1'b1, 1'b1);
    i_mc.recv(stall);
    for (i = 0; i < 46; i++)
    begin
      e = i < 16 ? 8'(i) ^ 8'h5A : 8'h00;
      if (i == 4)
        e = LSQR_RSP_TYPE;
      if (i >= 20 && i < 32)
        e = v[8 * (31 - i) +: 8];
      chkByte(i_mc.rsp[i], e);
      chkBit(i_mc.lastSeen[i], i == 45);
    end
    chkBit(cmdReady, 1'b1);
  endtask

  // A refused or ignored query: a drop pulse as expected, and no response open one cycle after it.
  task automatic badQ(input logic [7:0] typeCode, input logic chk, id, expDrop);
    i_mc.send(typeCode, chk, id);
    chkBit(queryDropped, expDrop);
    @(negedge clk);
    chkBit(queryDropped, 1'b0);
    chkBit(rspValid, 1'b0);
  endtask

  initial
  begin
    rstn = 1'b0;
    {linkUp, energyEfficientEthernet, lowPowerIdleState, anEnabled} = 4'h0;
    {anComplete, parallelDetect, serdesLink} = 3'h0;
    modeValid = 1'b1;
    highestCommonMode = 4'h0;
    enhancedSpeed = 8'h3C;
    otherIndications = 32'hA1B2C3D4;
    oemLinkStatus = 32'h5E6F7081;
    repeat (10) @(negedge clk);
    chkBit(cmdReady, 1'b1);
    chkBit(rspValid, 1'b0);
    chkBit(queryDropped, 1'b0);
    rstn = 1'b1;
    @(negedge clk);
    for (m = 0; m < 16; m++)
      run(1, 0, 0, 0, 0, 4'(m), m == 5 ? 4'h6 : m == 14 ? 4'hD : 4'(m), m == 3);
    run(1, 1, 0, 0, 0, 4'h6, 4'h0, 0);
    run(1, 1, 1, 1, 0, 4'h7, 4'h7, 1);
    run(1, 1, 1, 0, 1, 4'h8, 4'h0, 0);
    modeValid = 1'b0;
    run(1, 0, 0, 0, 0, 4'h3, 4'h0, 0);
    modeValid = 1'b1;
    energyEfficientEthernet = 1'b1;
    lowPowerIdleState = 1'b1;
    run(0, 0, 0, 0, 0, 4'h3, 4'h3, 0);
    energyEfficientEthernet = 1'b0;
    run(0, 0, 0, 0, 0, 4'h3, 4'h3, 0);
    badQ(LSQR_CMD_TYPE, 1'b0, 1'b1, 1'b1);
    badQ(LSQR_CMD_TYPE, 1'b1, 1'b0, 1'b1);
    badQ(8'h0B, 1'b1, 1'b1, 1'b0);
    run(1, 1, 1, 0, 0, 4'h4, 4'h4, 1);
    end_sim;
  end
endmodule
